// File: rtl/gpt_core.sv
// One timer channel: waveform generation, width/period capture, external event counting.
// Assumes a synchronised pin input and register writes from the bus slave above.
`timescale 1ns/10ps
module gpt_core (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [5:0] cfg,
  input wire logic cnt_wr,
  input wire logic per_wr,
  input wire logic wid_wr,
  input wire logic [31:0] wdata,
  input wire logic pin_in,
  output logic [31:0] count,
  output logic [31:0] period,
  output logic [31:0] width,
  output logic pin_out,
  output logic pin_oe,
  output logic ev_period,
  output logic ev_ovf
);
  gpt_pkg::gpt_mode_t mode;
  logic [31:0] cnt_q;
  logic [31:0] per_q;
  logic [31:0] wid_q;
  logic pin_q;
  logic in_d1_q;
  logic en_d1_q;
  logic ev_p_q;
  logic ev_o_q;
  logic is_pwm;
  logic is_cap;
  logic is_ext;
  logic rise;
  logic fall;
  logic per_end;
  logic pol;
  logic lvl;
  logic lvl_d1;
  assign mode = gpt_pkg::gpt_mode_t'(cfg[gpt_pkg::CFG_MODE_LSB +: 2]);
  assign pol = cfg[gpt_pkg::CFG_POL_BIT];
  assign is_pwm = (mode == gpt_pkg::MODE_PWMOUT);
  assign is_cap = (mode == gpt_pkg::MODE_WDTH_CAP);
  assign is_ext = (mode == gpt_pkg::MODE_EXT_CLK);
  // Polarity folds into the edge detect so capture works on either pulse sense
  assign lvl = pin_in ^ pol;
  assign lvl_d1 = in_d1_q ^ pol;
  assign rise = lvl & ~lvl_d1;
  assign fall = ~lvl & lvl_d1;
  assign per_end = (cnt_q >= per_q - 32'h0000_0001);
  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cnt_q <= gpt_pkg::RST_COUNT;
      per_q <= gpt_pkg::RST_PERIOD;
      wid_q <= gpt_pkg::RST_WIDTH;
      in_d1_q <= 1'b1;
      en_d1_q <= 1'b0;
      pin_q <= 1'b0;
      ev_p_q <= 1'b0;
      ev_o_q <= 1'b0;
    end else begin
      in_d1_q <= pin_in;
      en_d1_q <= enable;
      ev_p_q <= 1'b0;
      ev_o_q <= 1'b0;
      if (per_wr) per_q <= wdata;
      if (wid_wr) wid_q <= wdata;
      if (cnt_wr) begin
        cnt_q <= wdata;
      end else if (enable && !en_d1_q && !is_ext) begin
        cnt_q <= 32'h0000_0000;
      end else if (enable && is_pwm) begin
        if (per_end) begin
          cnt_q <= 32'h0000_0000;
          ev_p_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 32'h0000_0001;
        end
        pin_q <= ((per_end ? 32'h0000_0000 : cnt_q + 32'h0000_0001) < wid_q) ^ pol;
      end else if (enable && is_cap) begin
        // Width captured on trailing edge, period on the next leading edge
        if (fall && !cfg[gpt_pkg::CFG_CAP_PERIOD_BIT]) begin
          wid_q <= cnt_q;
          ev_p_q <= 1'b1;
        end
        if (rise) begin
          if (cfg[gpt_pkg::CFG_CAP_PERIOD_BIT]) ev_p_q <= 1'b1;
          per_q <= cnt_q;
          cnt_q <= 32'h0000_0001;
        end else if (cnt_q == 32'hFFFF_FFFF) begin
          ev_o_q <= 1'b1;
          cnt_q <= 32'h0000_0000;
        end else begin
          cnt_q <= cnt_q + 32'h0000_0001;
        end
      end else if (enable && is_ext && rise) begin
        // Watchdog: counts pin events and flags when period is reached
        if (per_end) begin
          cnt_q <= 32'h0000_0000;
          ev_p_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 32'h0000_0001;
        end
      end
      if (!enable || !is_pwm) pin_q <= pol;
    end
  end
  assign pin_out = pin_q;
  assign pin_oe = is_pwm & enable;
  assign count = cnt_q;
  assign period = per_q;
  assign width = wid_q;
  assign ev_period = ev_p_q & cfg[gpt_pkg::CFG_IRQ_EN_BIT];
  assign ev_ovf = ev_o_q & cfg[gpt_pkg::CFG_IRQ_EN_BIT];

  a_pwm_reload: assert property (@(posedge clock) disable iff (!reset_n)
    (enable && is_pwm && !cnt_wr && en_d1_q && per_end) |=> (cnt_q == 32'h0000_0000))
    else $error("count not reloaded at period end");
  a_pin_dir: assert property (@(posedge clock) disable iff (!reset_n)
    pin_oe |-> (mode == gpt_pkg::MODE_PWMOUT))
    else $error("pin driven outside waveform mode");
  a_cap_width: assert property (@(posedge clock) disable iff (!reset_n)
    (enable && en_d1_q && !cnt_wr && is_cap && fall && !cfg[gpt_pkg::CFG_CAP_PERIOD_BIT] && !wid_wr)
    |=> (wid_q == $past(cnt_q)))
    else $error("width capture lost");
  a_off_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    (!enable && !cnt_wr) |=> (cnt_q == $past(cnt_q)))
    else $error("disabled timer counted");
endmodule // gpt_core

// File: rtl/gpt_pkg.sv
// Package for the general-purpose timer pair: register map, fields, modes, reset values.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package gpt_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFF_TIMER_BASE = 8'h10;
  localparam logic [7:0] OFF_TIMER_STRIDE = 8'h10;
  localparam logic [3:0] OFF_MODE_CONFIG = 4'h0;
  localparam logic [3:0] OFF_CURRENT_COUNT = 4'h4;
  localparam logic [3:0] OFF_PERIOD_VALUE = 4'h8;
  localparam logic [3:0] OFF_PULSE_WIDTH = 4'hC;
  // ----------------------------------------------------------------
  // Configuration field layout
  // ----------------------------------------------------------------
  localparam int CFG_WIDTH = 6;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_POL_BIT = 2;
  localparam int CFG_IRQ_EN_BIT = 3;
  localparam int CFG_CAP_PERIOD_BIT = 4;
  localparam int CFG_RUN_EMU_BIT = 5;
  // Control/status layout: enable bits [1:0], running status bits [9:8]
  localparam int CTRL_RUN_LSB = 8;
  // Interrupt status layout per timer: bit 2*i = period/capture, 2*i+1 = overflow
  localparam int IRQ_BITS = 4;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] RST_CONFIG = 6'h00;
  localparam logic [31:0] RST_COUNT = 32'h0000_0000;
  localparam logic [31:0] RST_PERIOD = 32'h0000_0000;
  localparam logic [31:0] RST_WIDTH = 32'h0000_0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_PWMOUT,
    MODE_WDTH_CAP,
    MODE_EXT_CLK
  } gpt_mode_t;
endpackage

// File: rtl/gpt_sync.sv
// Two-flop synchroniser for a pin input.
// Assumes the input is asynchronous to clock.
`timescale 1ns/10ps
module gpt_sync (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  logic sync_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      // Pins idle high behind their pull-ups; resetting to that level avoids a false edge
      meta_q <= 1'b1;
      sync_q <= 1'b1;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // gpt_sync

// File: rtl/gpt_top.sv
// Top of the general-purpose timer pair: APB slave, shared control, interrupts, two channels.
// Assumes APB3 signalling on clock; pins reach the outside through the signal_routing_unit.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
// Overview of operation
// - Each timer picks its own mode: waveform output, width/period capture or external event watchdog.
// - Two timer instances exist and each can raise a periodic interrupt.
// - Each timer owns one two-way pin, driven in waveform mode while enabled and sampled otherwise.
// - Each timer has a 6-bit configuration register selecting and governing its mode.
// - Each timer has 32-bit count, period and pulse width registers.
// - One shared control register holds both timer enables; each write sets the whole enable mask.
// - Each timer pin is presented as separate in/out/enable signals for the signal_routing_unit.
// - Capture of pulse width and period supports bit-rate detection alongside the serial receiver.
module gpt_top #(
  parameter int NUM_TIMERS = 2
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_TIMERS-1:0] tmr_pin_in,
  output logic [NUM_TIMERS-1:0] tmr_pin_out,
  output logic [NUM_TIMERS-1:0] tmr_pin_oe,
  output logic irq
);
  if (NUM_TIMERS != 2) begin : g_count_check
    $error("gpt_top supports exactly two timers");
  end
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic acc;
  logic wr;
  logic rd;
  logic [NUM_TIMERS-1:0] en_q;
  logic [NUM_TIMERS-1:0] en_d;
  logic [gpt_pkg::IRQ_BITS-1:0] ist_q;
  logic [gpt_pkg::IRQ_BITS-1:0] ist_d;
  logic [gpt_pkg::IRQ_BITS-1:0] imask_q;
  logic [gpt_pkg::IRQ_BITS-1:0] ev;
  logic [5:0] cfg_q [NUM_TIMERS];
  logic [31:0] cnt [NUM_TIMERS];
  logic [31:0] per [NUM_TIMERS];
  logic [31:0] wid [NUM_TIMERS];
  logic [31:0] tmr_rd [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] tmr_hit;
  logic [NUM_TIMERS-1:0] pin_s;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic glob_hit;
  logic ist_rd;

  // Timer select from address: window index and word alignment
  function automatic logic timer_sel(input logic [7:0] a, input int idx);
    timer_sel = (a[7:4] == 4'(idx + 1)) && (a[1:0] == 2'b00);
  endfunction

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign pready = 1'b1;
  assign ist_rd = rd && (paddr == gpt_pkg::OFF_IRQ_STATUS);
  assign glob_hit = (paddr == gpt_pkg::OFF_CTRL_STATUS) || (paddr == gpt_pkg::OFF_IRQ_STATUS)
    || (paddr == gpt_pkg::OFF_IRQ_MASK);
  assign pslverr = acc & ~glob_hit & ~(|tmr_hit);

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < NUM_TIMERS; i++) begin : g_tmr
      logic sel;
      assign sel = timer_sel(paddr, i);
      assign tmr_hit[i] = sel;
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          cfg_q[i] <= gpt_pkg::RST_CONFIG;
        end else if (wr && sel && paddr[3:0] == gpt_pkg::OFF_MODE_CONFIG) begin
          cfg_q[i] <= pwdata[5:0];
        end
      end
      gpt_sync u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in(tmr_pin_in[i]),
        .sync_out(pin_s[i])
      );
      gpt_core u_core (
        .clock(clock),
        .reset_n(reset_n),
        .enable(en_q[i]),
        .cfg(cfg_q[i]),
        .cnt_wr(wr && sel && paddr[3:0] == gpt_pkg::OFF_CURRENT_COUNT),
        .per_wr(wr && sel && paddr[3:0] == gpt_pkg::OFF_PERIOD_VALUE),
        .wid_wr(wr && sel && paddr[3:0] == gpt_pkg::OFF_PULSE_WIDTH),
        .wdata(pwdata),
        .pin_in(pin_s[i]),
        .count(cnt[i]),
        .period(per[i]),
        .width(wid[i]),
        .pin_out(tmr_pin_out[i]),
        .pin_oe(tmr_pin_oe[i]),
        .ev_period(ev[2*i]),
        .ev_ovf(ev[2*i+1])
      );
      assign tmr_rd[i] = (paddr[3:0] == gpt_pkg::OFF_MODE_CONFIG) ? {26'h0, cfg_q[i]} :
                         (paddr[3:0] == gpt_pkg::OFF_CURRENT_COUNT) ? cnt[i] :
                         (paddr[3:0] == gpt_pkg::OFF_PERIOD_VALUE) ? per[i] : wid[i];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Control, status and interrupts
  // ----------------------------------------------------------------
  // Enable bits are written together; the write value is the full new mask
  assign en_d = (wr && paddr == gpt_pkg::OFF_CTRL_STATUS) ? pwdata[NUM_TIMERS-1:0] : en_q;
  // Set wins over read-clear so an event in the clearing cycle survives
  // Only bits already returned in the setup-cycle snapshot are cleared, so an event
  // landing between setup and access is kept for the next read
  assign ist_d = (ist_rd ? (ist_q & ~rdata_q[gpt_pkg::IRQ_BITS-1:0]) : ist_q) | ev;
  assign rd_mux = (paddr == gpt_pkg::OFF_CTRL_STATUS) ?
                  (32'(en_q) | (32'(en_q) << gpt_pkg::CTRL_RUN_LSB)) :
                  (paddr == gpt_pkg::OFF_IRQ_STATUS) ? 32'(ist_q) :
                  (paddr == gpt_pkg::OFF_IRQ_MASK) ? 32'(imask_q) :
                  tmr_hit[0] ? tmr_rd[0] :
                  tmr_hit[1] ? tmr_rd[1] : gpt_pkg::RD_UNMAPPED;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      en_q <= '0;
      ist_q <= '0;
      imask_q <= '0;
      rdata_q <= gpt_pkg::RD_UNMAPPED;
    end else begin
      en_q <= en_d;
      ist_q <= ist_d;
      if (wr && paddr == gpt_pkg::OFF_IRQ_MASK) imask_q <= pwdata[gpt_pkg::IRQ_BITS-1:0];
      if (psel && !penable && !pwrite) rdata_q <= rd_mux;
    end
  end
  // Data is latched in setup, so the zero-wait access phase returns a registered value
  assign prdata = rdata_q;
  assign irq = |(ist_q & imask_q);

  a_irq_level: assert property (@(posedge clock) disable iff (!reset_n)
    (|(ist_q & imask_q)) |-> irq)
    else $error("interrupt not raised");
  a_event_sticky: assert property (@(posedge clock) disable iff (!reset_n)
    (|ev) |=> ((ist_q & $past(ev)) == $past(ev)))
    else $error("event lost");
  a_enable_indep: assert property (@(posedge clock) disable iff (!reset_n)
    !(wr && paddr == gpt_pkg::OFF_CTRL_STATUS) |=> (en_q == $past(en_q)))
    else $error("enable changed without write");
  a_cfg_write: assert property (@(posedge clock) disable iff (!reset_n)
    (wr && tmr_hit[0] && paddr[3:0] == gpt_pkg::OFF_MODE_CONFIG) |=> (cfg_q[0] == $past(pwdata[5:0])))
    else $error("config write lost");
endmodule // gpt_top

// File: verification/gpt_pin_model.sv
// Far side of one timer pin: a pulse source that can also be overdriven by the timer.
// Assumes the bench changes run and lengths just after a rising clock edge.
`timescale 1ns/10ps
module gpt_pin_model (
  input wire logic clock,
  input wire logic run,
  input wire logic [7:0] hi_len,
  input wire logic [7:0] lo_len,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_in
);
  logic level_q;
  logic [7:0] left_q;
  // Idle level is high: the pin has a pull-up, so a stopped source reads as one
  always_ff @(posedge clock) begin
    if (!run) begin
      level_q <= 1'b1;
      left_q <= 8'h00;
    end else if (left_q == 8'h00) begin
      level_q <= ~level_q;
      left_q <= (level_q ? lo_len : hi_len) - 8'h01;
    end else begin
      left_q <= left_q - 8'h01;
    end
  end
  // The wire follows the timer whenever it drives, otherwise the source
  assign pin_in = pin_oe ? pin_out : level_q;
endmodule // gpt_pin_model

// File: verification/testbench.sv
// Self-checking bench for the timer pair: APB master, pin sources, scenario tasks.
// Assumes the zero-wait APB slave and register map of the design package.
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] tmr_pin_in;
  logic [1:0] tmr_pin_out;
  logic [1:0] tmr_pin_oe;
  logic irq;
  logic [1:0] run = 2'b00;
  logic [7:0] hi_len [2] = '{8'h07, 8'h07};
  logic [7:0] lo_len [2] = '{8'h05, 8'h05};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2.5 clock = ~clock;
  gpt_top #(.NUM_TIMERS(2)) u_gpt_top (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tmr_pin_in(tmr_pin_in), .tmr_pin_out(tmr_pin_out), .tmr_pin_oe(tmr_pin_oe), .irq(irq));
  for (genvar i = 0; i < 2; i++) begin : g_pin
    gpt_pin_model u_gpt_pin_model (.clock(clock), .run(run[i]), .hi_len(hi_len[i]), .lo_len(lo_len[i]),
      .pin_out(tmr_pin_out[i]), .pin_oe(tmr_pin_oe[i]), .pin_in(tmr_pin_in[i]));
  end
  // ----------------------------------------------------------------
  // Bus master and helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
  endtask
  function automatic logic [7:0] ta(input int i, input logic [3:0] off);
    return gpt_pkg::OFF_TIMER_BASE + 8'(i) * gpt_pkg::OFF_TIMER_STRIDE + {4'h0, off};
  endfunction
  // Counts high pin cycles of timer 0 over one full period
  task automatic highs(input int n, output logic [31:0] h);
    h = 32'h0000_0000;
    repeat (n) begin
      @(posedge clock);
      h += {31'h0, tmr_pin_out[0]};
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    logic [3:0] offs [4] = '{gpt_pkg::OFF_MODE_CONFIG, gpt_pkg::OFF_CURRENT_COUNT, gpt_pkg::OFF_PERIOD_VALUE,
                             gpt_pkg::OFF_PULSE_WIDTH};
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 4; k++) begin
        rd(ta(i, offs[k]), q);
        `CHK(q, 32'h0000_0000)
      end
    end
    rd(gpt_pkg::OFF_CTRL_STATUS, q);
    `CHK(q, 32'h0000_0000)
    apb(1'b0, 8'h0C, 32'h0000_0000, q, e);
    `CHK({q, e}, {gpt_pkg::RD_UNMAPPED, 1'b1})
    apb(1'b1, 8'h40, 32'hFFFF_FFFF, q, e);
    `CHK(e, 1'b1)
    $display("test reset done");
  endtask
  task automatic t_regs();
    logic [31:0] q;
    for (int i = 0; i < 2; i++) begin
      wr(ta(i, gpt_pkg::OFF_MODE_CONFIG), 32'hFFFF_FFFF);
      rd(ta(i, gpt_pkg::OFF_MODE_CONFIG), q);
      `CHK(q, 32'h0000_003F)
      wr(ta(i, gpt_pkg::OFF_MODE_CONFIG), 32'h0000_0000);
      wr(ta(i, gpt_pkg::OFF_PERIOD_VALUE), 32'hA5C3_0F01 + i);
      wr(ta(i, gpt_pkg::OFF_PULSE_WIDTH), 32'h5A3C_F0FE + i);
      wr(ta(i, gpt_pkg::OFF_CURRENT_COUNT), 32'hFFFF_FFFE - i);
      rd(ta(i, gpt_pkg::OFF_PERIOD_VALUE), q);
      `CHK(q, 32'hA5C3_0F01 + i)
      rd(ta(i, gpt_pkg::OFF_PULSE_WIDTH), q);
      `CHK(q, 32'h5A3C_F0FE + i)
      rd(ta(i, gpt_pkg::OFF_CURRENT_COUNT), q);
      `CHK(q, 32'hFFFF_FFFE - i)
    end
    $display("test regs done");
  endtask
  task automatic t_wave();
    logic [31:0] q;
    wr(ta(0, gpt_pkg::OFF_PERIOD_VALUE), 32'h0000_000A);
    wr(ta(0, gpt_pkg::OFF_PULSE_WIDTH), 32'h0000_0003);
    wr(ta(0, gpt_pkg::OFF_MODE_CONFIG), 32'h0000_0009);
    wr(gpt_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    wr(gpt_pkg::OFF_CTRL_STATUS, 32'h0000_0001);
    repeat (20) @(posedge clock);
    highs(10, q);
    `CHK(q, 32'h0000_0003)
    `CHK(tmr_pin_oe, 2'b01)
    `CHK(irq, 1'b1)
    rd(gpt_pkg::OFF_IRQ_STATUS, q);
    `CHK(q[0], 1'b1)
    wr(gpt_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge clock);
    `CHK(irq, 1'b0)
    wr(ta(0, gpt_pkg::OFF_MODE_CONFIG), 32'h0000_0009 | (1 << gpt_pkg::CFG_POL_BIT));
    repeat (12) @(posedge clock);
    highs(10, q);
    `CHK(q, 32'h0000_0007)
    wr(gpt_pkg::OFF_CTRL_STATUS, 32'h0000_0000);
    repeat (2) @(posedge clock);
    `CHK(tmr_pin_oe, 2'b00)
    $display("test wave done");
  endtask
  task automatic t_capture();
    logic [31:0] q;
    wr(ta(1, gpt_pkg::OFF_MODE_CONFIG), 32'h0000_0002);
    wr(gpt_pkg::OFF_CTRL_STATUS, 32'h0000_0002);
    run <= 2'b10;
    repeat (60) @(posedge clock);
    `CHK(tmr_pin_oe, 2'b00)
    rd(ta(1, gpt_pkg::OFF_PERIOD_VALUE), q);
    `CHK(q, 32'h0000_000C)
    rd(ta(1, gpt_pkg::OFF_PULSE_WIDTH), q);
    `CHK(q, 32'h0000_0007)
    // Period-edge events with the interrupt on; the first status read only clears older events
    wr(ta(1, gpt_pkg::OFF_MODE_CONFIG), 32'h0000_001A);
    rd(gpt_pkg::OFF_IRQ_STATUS, q);
    repeat (30) @(posedge clock);
    rd(gpt_pkg::OFF_IRQ_STATUS, q);
    `CHK(q, 32'h0000_0004)
    // Pin left idle high, count placed just below the wrap to reach the overflow event
    run <= 2'b00;
    repeat (8) @(posedge clock);
    wr(ta(1, gpt_pkg::OFF_CURRENT_COUNT), 32'hFFFF_FFF0);
    repeat (24) @(posedge clock);
    rd(gpt_pkg::OFF_IRQ_STATUS, q);
    `CHK(q[3], 1'b1)
    wr(gpt_pkg::OFF_CTRL_STATUS, 32'h0000_0000);
    $display("test capture done");
  endtask
  task automatic t_event();
    logic [31:0] q;
    hi_len[0] <= 8'h03;
    lo_len[0] <= 8'h03;
    wr(ta(0, gpt_pkg::OFF_MODE_CONFIG), 32'h0000_0003);
    wr(ta(0, gpt_pkg::OFF_PERIOD_VALUE), 32'h0000_0064);
    wr(ta(0, gpt_pkg::OFF_CURRENT_COUNT), 32'h0000_0000);
    wr(gpt_pkg::OFF_CTRL_STATUS, 32'h0000_0001);
    run <= 2'b01;
    // Stop in a high phase so the idle pull-up adds no rising edge
    repeat (10) @(posedge clock);
    run <= 2'b00;
    repeat (8) @(posedge clock);
    rd(ta(0, gpt_pkg::OFF_CURRENT_COUNT), q);
    `CHK(q, 32'h0000_0002)
    $display("test event done");
  endtask
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Ceiling well above the roughly 370 cycles the scenarios need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_regs();
    t_wave();
    t_capture();
    t_event();
    give_verdict();
  end
endmodule // testbench
